// ### hdl/lgp_cfg_if.sv
// interface: per-pin mode and output value from the register file to the pin logic
`timescale 1ns/100ps
`default_nettype none
interface lgp_cfg_if;
	logic [7:0] mode;
	logic [3:0] val;
	modport regs (output mode, output val);
	modport pins (input mode, input val);
endinterface
`default_nettype wire

// ### hdl/lgp_pin_ctrl.sv
// module: per-pin drive and input gating from the configured mode
`timescale 1ns/100ps
`default_nettype none
module lgp_pin_ctrl #(
	parameter int NUM_PINS = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// configuration
	lgp_cfg_if.pins cfg,
	// pad side
	input wire logic [NUM_PINS-1:0] pin_in,
	output logic [NUM_PINS-1:0] pin_out,
	output logic [NUM_PINS-1:0] pin_oe_n,
	// core side
	output logic [NUM_PINS-1:0] func_in,
	output logic [NUM_PINS-1:0] gp_in
);
	logic [NUM_PINS-1:0] sync1_ff;
	logic [NUM_PINS-1:0] sync2_ff;

	// ==========================================
	// pad input synchroniser
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= pin_in;
			sync2_ff <= sync1_ff;
		end
	end

	// ==========================================
	// per-pin mode decode
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_out <= '0;
			pin_oe_n <= '1;
			func_in <= '0;
			gp_in <= '0;
		end else begin
			for (int i = 0; i < NUM_PINS; i++) begin
				pin_out[i] <= cfg.val[i];
				pin_oe_n[i] <= (cfg.mode[2*i +: 2] != lgp_pkg::LGP_MODE_OUT);
				func_in[i] <= (cfg.mode[2*i +: 2] == lgp_pkg::LGP_MODE_FUNC) & sync2_ff[i];
				gp_in[i] <= (cfg.mode[2*i +: 2] == lgp_pkg::LGP_MODE_IN) & sync2_ff[i];
			end
		end
	end

	a_drive_mode: assert property (@(posedge clk) disable iff (rst)
		1 |=> (pin_oe_n[0] == ($past(cfg.mode[1:0]) != 2'b01)))
		else $error("pin five drive does not follow its mode");
	a_hiz_float: assert property (@(posedge clk) disable iff (rst)
		cfg.mode[3:2] == 2'b10 |=> pin_oe_n[1])
		else $error("pin six driven in high impedance mode");
	a_gp_input: assert property (@(posedge clk) disable iff (rst)
		cfg.mode[5:4] == 2'b11 |=> !func_in[2] && pin_oe_n[2])
		else $error("pin seven general input misrouted");
	a_drive_level: assert property (@(posedge clk) disable iff (rst)
		!pin_oe_n[3] |-> pin_out[3] == $past(cfg.val[3]))
		else $error("pin eight level differs from its value bit");
	a_func_path: assert property (@(posedge clk) disable iff (rst)
		cfg.mode[1:0] == 2'b00 |=> !gp_in[0] && pin_oe_n[0])
		else $error("pin five functional mode misrouted");
endmodule
`default_nettype wire

// ### hdl/lgp_pkg.sv
// package: register map, field layout and mode codes of the local pin configuration block
`default_nettype none
package lgp_pkg;
	// ==========================================
	// register offsets on the serial control bus
	localparam logic [7:0] LGP_OFS_FIVE_SIX = 8'h10;
	localparam logic [7:0] LGP_OFS_SEVEN_EIGHT = 8'h11;
	// ==========================================
	// field layout inside each configuration register
	localparam int LGP_LO_MODE_POS = 0;
	localparam int LGP_LO_VAL_POS = 3;
	localparam int LGP_HI_MODE_POS = 4;
	localparam int LGP_HI_VAL_POS = 7;
	localparam logic [7:0] LGP_WRITE_MASK = 8'hbb;
	localparam logic [7:0] LGP_RST_CFG = 8'h00;
	localparam int LGP_NUM_PINS = 4;
	// ==========================================
	// pin modes
	typedef enum logic [1:0] {
		LGP_MODE_FUNC = 2'b00,
		LGP_MODE_OUT = 2'b01,
		LGP_MODE_HIZ = 2'b10,
		LGP_MODE_IN = 2'b11
	} lgp_mode_t;
endpackage
`default_nettype wire

// ### hdl/lgp_top.sv
// module: local pin five to eight configuration registers and pin control
// Operation
// - mode 00 routes pin to functional input; mode 10 makes it high impedance.
// - mode 01 makes pin a general output; mode 11 a general input.
// - stored value drives pin only in general output mode.
// - value 0 drives low, 1 drives high; value resets to 0.
// - pin six value sits in bit 7 of register 0x10; reset zero.
`timescale 1ns/100ps
`default_nettype none
module lgp_top (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register access port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// pads: pins five to eight in bit order
	input wire logic [3:0] pin_in,
	output logic [3:0] pin_out,
	output logic [3:0] pin_oe_n,
	// core side
	output logic [3:0] func_in,
	output logic [3:0] gp_in
);
	logic [7:0] five_six_ff;
	logic [7:0] seven_eight_ff;
	logic [7:0] nxt_rdata;

	lgp_cfg_if cfg ();

	// ==========================================
	// address and field decode
	function automatic logic hits_five_six(input logic [7:0] addr);
		return addr == lgp_pkg::LGP_OFS_FIVE_SIX;
	endfunction

	function automatic logic hits_seven_eight(input logic [7:0] addr);
		return addr == lgp_pkg::LGP_OFS_SEVEN_EIGHT;
	endfunction

	// mode field of the low or the high pin of one register
	function automatic logic [1:0] mode_of(input logic [7:0] cfg_reg, input logic hi);
		return hi ? cfg_reg[lgp_pkg::LGP_HI_MODE_POS +: 2] :
			cfg_reg[lgp_pkg::LGP_LO_MODE_POS +: 2];
	endfunction

	// value bit of the low or the high pin of one register
	function automatic logic val_of(input logic [7:0] cfg_reg, input logic hi);
		return hi ? cfg_reg[lgp_pkg::LGP_HI_VAL_POS] :
			cfg_reg[lgp_pkg::LGP_LO_VAL_POS];
	endfunction

	// ==========================================
	// register write
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			five_six_ff <= lgp_pkg::LGP_RST_CFG;
			seven_eight_ff <= lgp_pkg::LGP_RST_CFG;
		end else if (reg_wr) begin
			if (hits_five_six(reg_addr)) begin
				five_six_ff <= reg_wdata & lgp_pkg::LGP_WRITE_MASK;
			end
			if (hits_seven_eight(reg_addr)) begin
				seven_eight_ff <= reg_wdata & lgp_pkg::LGP_WRITE_MASK;
			end
		end
	end

	// ==========================================
	// register read
	always_comb begin
		nxt_rdata = 8'h00;
		unique case (reg_addr)
			lgp_pkg::LGP_OFS_FIVE_SIX: nxt_rdata = five_six_ff;
			lgp_pkg::LGP_OFS_SEVEN_EIGHT: nxt_rdata = seven_eight_ff;
			default: nxt_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rdata <= reg_rd ? nxt_rdata : 8'h00;
			reg_rvalid <= reg_rd;
		end
	end

	// ==========================================
	// field unpacking
	// pin six value in bit 7
	assign cfg.mode = {mode_of(seven_eight_ff, 1'b1),
		mode_of(seven_eight_ff, 1'b0),
		mode_of(five_six_ff, 1'b1),
		mode_of(five_six_ff, 1'b0)};
	assign cfg.val = {val_of(seven_eight_ff, 1'b1),
		val_of(seven_eight_ff, 1'b0),
		val_of(five_six_ff, 1'b1),
		val_of(five_six_ff, 1'b0)};

	lgp_pin_ctrl #(
		.NUM_PINS(lgp_pkg::LGP_NUM_PINS)
	) u_pins (
		.clk(clk),
		.rst(rst),
		.cfg(cfg),
		.pin_in(pin_in),
		.pin_out(pin_out),
		.pin_oe_n(pin_oe_n),
		.func_in(func_in),
		.gp_in(gp_in)
	);

	// ==========================================
	// register bus checks
	a_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
		reg_rvalid |-> (reg_rdata & ~lgp_pkg::LGP_WRITE_MASK) == 8'h00)
		else $error("reserved bit read as one");

	a_rsvd_store: assert property (@(posedge clk) disable iff (rst)
		(five_six_ff & ~lgp_pkg::LGP_WRITE_MASK) == 8'h00 &&
		(seven_eight_ff & ~lgp_pkg::LGP_WRITE_MASK) == 8'h00)
		else $error("reserved bit stored as one");

	a_read_back: assert property (@(posedge clk) disable iff (rst)
		reg_wr && reg_addr == 8'h11 ##1 reg_rd && reg_addr == 8'h11 && !reg_wr
		|=> reg_rdata == ($past(reg_wdata, 2) & lgp_pkg::LGP_WRITE_MASK))
		else $error("read back differs from masked write");

	a_five_mask: assert property (@(posedge clk) disable iff (rst)
		reg_wr && hits_five_six(reg_addr)
		|=> five_six_ff == ($past(reg_wdata) & lgp_pkg::LGP_WRITE_MASK))
		else $error("pin five and six register not masked on write");

	a_eight_mask: assert property (@(posedge clk) disable iff (rst)
		reg_wr && hits_seven_eight(reg_addr)
		|=> seven_eight_ff == ($past(reg_wdata) & lgp_pkg::LGP_WRITE_MASK))
		else $error("pin seven and eight register not masked on write");

	a_unmapped_write: assert property (@(posedge clk) disable iff (rst)
		reg_wr && !hits_five_six(reg_addr) && !hits_seven_eight(reg_addr)
		|=> $stable(five_six_ff) && $stable(seven_eight_ff))
		else $error("write to unmapped address changed a register");

	a_unmapped_read: assert property (@(posedge clk) disable iff (rst)
		reg_rd && !hits_five_six(reg_addr) && !hits_seven_eight(reg_addr)
		|=> reg_rvalid && reg_rdata == 8'h00)
		else $error("read of unmapped address not zero");

	a_read_five: assert property (@(posedge clk) disable iff (rst)
		reg_rd && hits_five_six(reg_addr) |=> reg_rdata == $past(five_six_ff))
		else $error("pin five and six register read wrong");

	a_read_eight: assert property (@(posedge clk) disable iff (rst)
		reg_rd && hits_seven_eight(reg_addr) |=> reg_rdata == $past(seven_eight_ff))
		else $error("pin seven and eight register read wrong");

	a_rd_quiet: assert property (@(posedge clk) disable iff (rst)
		!reg_rd |=> !reg_rvalid && reg_rdata == 8'h00)
		else $error("read answer without a read");

	// ==========================================
	// pin checks
	a_six_value: assert property (@(posedge clk) disable iff (rst)
		reg_wr && reg_addr == 8'h10 |=> ##1 pin_out[1] == $past(reg_wdata[7], 2))
		else $error("pin six value not taken from bit 7");

	a_reset_low: assert property (@(posedge clk) disable iff (rst)
		$fell(rst) |-> pin_out == 4'h0)
		else $error("pin value not low after reset");

	a_reset_float: assert property (@(posedge clk) disable iff (rst)
		$fell(rst) |-> pin_oe_n == 4'hf)
		else $error("pin driven right after reset");

	a_val_follows: assert property (@(posedge clk) disable iff (rst)
		1 |=> pin_out == $past({seven_eight_ff[7], seven_eight_ff[3],
			five_six_ff[7], five_six_ff[3]}))
		else $error("pin level differs from stored value bits");

	a_six_drive: assert property (@(posedge clk) disable iff (rst)
		1 |=> pin_oe_n[1] == ($past(five_six_ff[5:4]) != 2'b01))
		else $error("pin six drive does not follow its mode");

	a_seven_drive: assert property (@(posedge clk) disable iff (rst)
		1 |=> pin_oe_n[2] == ($past(seven_eight_ff[1:0]) != 2'b01))
		else $error("pin seven drive does not follow its mode");

	a_eight_drive: assert property (@(posedge clk) disable iff (rst)
		1 |=> pin_oe_n[3] == ($past(seven_eight_ff[5:4]) != 2'b01))
		else $error("pin eight drive does not follow its mode");

	a_eight_hiz: assert property (@(posedge clk) disable iff (rst)
		seven_eight_ff[5:4] == 2'b10 |=> pin_oe_n[3] && !func_in[3] && !gp_in[3])
		else $error("pin eight not floating in high impedance mode");

	a_seven_func: assert property (@(posedge clk) disable iff (rst)
		seven_eight_ff[1:0] == 2'b00 |=> pin_oe_n[2] && !gp_in[2])
		else $error("pin seven functional mode misrouted");

	a_eight_gp: assert property (@(posedge clk) disable iff (rst)
		seven_eight_ff[5:4] == 2'b11 |=> pin_oe_n[3] && !func_in[3])
		else $error("pin eight general input misrouted");

	a_five_gp: assert property (@(posedge clk) disable iff (rst)
		five_six_ff[1:0] == 2'b11 |=> pin_oe_n[0] && !func_in[0])
		else $error("pin five general input misrouted");

	a_six_func: assert property (@(posedge clk) disable iff (rst)
		five_six_ff[5:4] == 2'b00 |=> pin_oe_n[1] && !gp_in[1])
		else $error("pin six functional mode misrouted");

	a_out_no_input: assert property (@(posedge clk) disable iff (rst)
		five_six_ff[1:0] == 2'b01 |=> !func_in[0] && !gp_in[0])
		else $error("pin five output mode feeds an input path");
endmodule
`default_nettype wire

// ### verification/lgp_top_tb.sv
// testbench: register access and pin mode checks of the local pin block
`timescale 1ns/100ps
`default_nettype none
module lgp_top_tb;
	logic clk;
	logic rst;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic reg_rvalid;
	logic [3:0] pin_in;
	logic [3:0] pin_out;
	logic [3:0] pin_oe_n;
	logic [3:0] func_in;
	logic [3:0] gp_in;
	logic [3:0] p;
	int n_fail = 0;
	int tests_run = 0;
	lgp_top uut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .func_in(func_in), .gp_in(gp_in));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ==========================================
	// access and compare tasks
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk("reg_rvalid", 8'h01, {7'h00, reg_rvalid});
		chk("reg_rdata", exp, reg_rdata);
	endtask
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk("reg_rdata", exp, reg_rdata);
	endtask
	// config needs two edges, pad sync three
	task automatic pins(input logic [3:0] oe, input logic [3:0] out, input logic [3:0] fi,
		input logic [3:0] gi);
		repeat (4) @(posedge clk);
		#1;
		chk("pin_oe_n", {4'h0, oe}, {4'h0, pin_oe_n});
		chk("pin_out", {4'h0, out}, {4'h0, pin_out});
		chk("func_in", {4'h0, fi}, {4'h0, func_in});
		chk("gp_in", {4'h0, gi}, {4'h0, gp_in});
	endtask
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// ==========================================
	// tests
	initial begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		pin_in = 4'ha;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		pins(4'hf, 4'h0, 4'ha, 4'h0);
		rd(lgp_pkg::LGP_OFS_FIVE_SIX, 8'h00);
		rd(lgp_pkg::LGP_OFS_SEVEN_EIGHT, 8'h00);
		$display("test reset done");
		wr(lgp_pkg::LGP_OFS_FIVE_SIX, 8'hff);
		rd(lgp_pkg::LGP_OFS_FIVE_SIX, 8'hbb);
		wr(lgp_pkg::LGP_OFS_SEVEN_EIGHT, 8'h44);
		rd(lgp_pkg::LGP_OFS_SEVEN_EIGHT, 8'h00);
		wr(8'h12, 8'hff);
		rd(8'h12, 8'h00);
		$display("test reserved done");
		for (int m = 0; m < 4; m++) begin
			p = m[0] ? 4'h5 : 4'ha;
			wr(lgp_pkg::LGP_OFS_FIVE_SIX, {2'b10, m[1:0], 2'b10, m[1:0]});
			wr(lgp_pkg::LGP_OFS_SEVEN_EIGHT, {2'b10, m[1:0], 2'b10, m[1:0]});
			pin_in <= p;
			pins((m == 1) ? 4'h0 : 4'hf, 4'hf, (m == 0) ? p : 4'h0, (m == 3) ? p : 4'h0);
		end
		$display("test modes done");
		wr(lgp_pkg::LGP_OFS_FIVE_SIX, 8'h11);
		wr(lgp_pkg::LGP_OFS_SEVEN_EIGHT, 8'h11);
		pins(4'h0, 4'h0, 4'h0, 4'h0);
		wr(lgp_pkg::LGP_OFS_FIVE_SIX, 8'h91);
		pins(4'h0, 4'h2, 4'h0, 4'h0);
		rd(lgp_pkg::LGP_OFS_FIVE_SIX, 8'h91);
		$display("test values done");
		wr_rd(lgp_pkg::LGP_OFS_SEVEN_EIGHT, 8'hee, 8'haa);
		$display("test back to back done");
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		pins(4'hf, 4'h0, 4'h5, 4'h0);
		rd(lgp_pkg::LGP_OFS_FIVE_SIX, 8'h00);
		rd(lgp_pkg::LGP_OFS_SEVEN_EIGHT, 8'h00);
		$display("test mid reset done");
		summarize();
	end
	initial begin
		repeat (2000) @(posedge clk);
		n_fail++;
		summarize();
	end
endmodule
`default_nettype wire
